// ### verilog/cnrb_pkg.sv
// Constants and types for the CAN receive buffer routing block
// Functional notes
// - Tx ident low bits 7-5 hold id bits
// - Extended enable selects extended id sending
// - Tx ident low bits 4, 2 read zero
// - Tx ident low bits 1-0 hold ext bits
// - Sixteen 4-bit filter buffer pointers, two per register
// - Pointer and tx ident regs absent mode 0
// - Assembly buffer always takes next frame
// - Accepted frame overwrites whole target buffer
// - Load sets full; full blocks further loads
// - Interrupt on each load when enabled
// - Record filter hit and remote request flag
// - Ident type flag: zero std, one ext
// - Mode 00 all, 01 std, 10 ext
// - Conflicting filter type never matches in mode 0
// - Modes 1/2: mask ext bit restricts type
// - Accept-all takes every frame, even partial
// - Filters pointing to transmit buffers discard frames
// - Mode 0: buffer 0 high priority, two filters
// - Double buffer spills to buffer 1 when buffer 0 is full
// - Modes 1/2: lowest numbered matching buffer loads
package cnrb_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] TX_IDENT_LOW_OFS = 12'h004;
    localparam logic [11:0] FILTER_EXT_OFS = 12'h008;
    localparam logic [11:0] BUF_CFG_OFS = 12'h00C;
    localparam logic [11:0] STATUS_OFS = 12'h010;
    localparam logic [11:0] FILTER_MAP_OFS = 12'h020;
    localparam logic [11:0] FILTER_MAP_END = 12'h03C;
    localparam logic [11:0] BUF_OFS = 12'h040;
    localparam logic [11:0] BUF_END = 12'h0BC;
    // ==========================================================
    // Field layout and reset values
    localparam logic [7:0] TX_IDENT_LOW_WMASK = 8'hEB;
    localparam int TX_EXT_BIT = 3;
    localparam logic [7:0] TX_IDENT_LOW_RST = 8'h00;
    localparam logic [7:0] MAP_RST_0 = 8'h00;
    localparam logic [7:0] MAP_RST_1 = 8'h11;
    localparam logic [7:0] MAP_RST_2 = 8'h11;
    localparam logic [7:0] MAP_RST_OTHER = 8'h00;
    localparam logic [1:0] OP_MODE0 = 2'h0;
    localparam logic [1:0] RXM_ALL = 2'h0;
    localparam logic [1:0] RXM_STD = 2'h1;
    localparam logic [1:0] RXM_EXT = 2'h2;
    localparam logic [1:0] RXM_ANY = 2'h3;
    localparam int NUM_FILT = 16;
    localparam int NUM_BUF = 8;
    localparam int NUM_MAP = 8;
    // ==========================================================
    // Routing state
    typedef enum logic {ST_IDLE, ST_ROUTE} cnrb_state_t;
endpackage : cnrb_pkg

// ### verilog/cnrb_top.sv
// CAN receive buffer routing with APB register access
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module cnrb_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frmDone,
    input wire logic frmError,
    input wire logic [28:0] frmIdent,
    input wire logic frmExt,
    input wire logic frmRtr,
    input wire logic [3:0] frmDlc,
    input wire logic [63:0] frmData,
    input wire logic [15:0] frmMatch,
    output logic rxIrq,
    output logic [7:0] rxBufferFull,
    output logic rxOverflow,
    output logic txExtIdent,
    output logic [7:0] txIdentLow
);
    // ==========================================================
    // State
    typedef struct packed {
        cnrb_pkg::cnrb_state_t state;
        logic [1:0] opMode;
        logic [1:0] rxMode0;
        logic [1:0] rxMode1;
        logic dblBuf;
        logic rxIntEn;
        logic [7:0] txIdent;
        logic [15:0] filtExt;
        logic [7:0] acceptAll;
        logic [7:0] maskExt;
        logic [5:0] progTx;
        logic [15:0][3:0] filtPtr;
        logic [7:0] full;
        logic overflow;
        logic [7:0][4:0] hit;
        logic [7:0] rtr;
        logic [7:0] ext;
        logic [7:0][3:0] dlc;
        logic [7:0][28:0] ident;
        logic [7:0][63:0] data;
        logic [28:0] mabIdent;
        logic mabExt;
        logic mabRtr;
        logic [3:0] mabDlc;
        logic [63:0] mabData;
        logic [15:0] mabMatch;
        logic mabPartial;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } cnrb_regs_t;

    cnrb_regs_t s_reg;
    cnrb_regs_t s_next;

    // ==========================================================
    // Lowest set bit of an eight bit vector
    function automatic logic [2:0] lowest8(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : lowest8

    // ==========================================================
    // Filter type check against receive mode
    function automatic logic typeOk(input logic [1:0] rm,
                                    input logic fExt,
                                    input logic mExt);
        logic r;
        r = 1'b0;
        case (rm)
            cnrb_pkg::RXM_ALL: r = (fExt == mExt);
            cnrb_pkg::RXM_STD: r = !fExt && !mExt;
            cnrb_pkg::RXM_EXT: r = fExt && mExt;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : typeOk

    // ==========================================================
    // Next state
    always_comb
    begin
        logic acc, wr, enh, load, ovf, err;
        logic [7:0] cand;
        logic [7:0][4:0] hitIdx;
        logic [3:0] p, bi;
        logic [2:0] pi, tgt, b;
        logic [31:0] rd;
        {acc, wr, enh, load, ovf, err} = 6'h00;
        cand = 8'h00;
        hitIdx = '0;
        {p, bi} = 8'h00;
        {pi, tgt, b} = 9'h000;
        rd = 32'h0000_0000;
        s_next = s_reg;
        s_next.irq = 1'b0;
        enh = (s_reg.opMode != cnrb_pkg::OP_MODE0);

        // Register read decode
        acc = psel && penable && !s_reg.ready;
        wr = psel && penable && s_reg.ready && pwrite;
        bi = paddr[7:4] - 4'h4;
        b = bi[2:0];
        if (paddr == cnrb_pkg::CTRL_OFS)
        begin
            rd = {24'h0, s_reg.rxIntEn, s_reg.dblBuf, s_reg.rxMode1,
                  s_reg.rxMode0, s_reg.opMode};
        end
        else if (paddr == cnrb_pkg::TX_IDENT_LOW_OFS)
        begin
            rd = enh ? {24'h0, s_reg.txIdent &
                        cnrb_pkg::TX_IDENT_LOW_WMASK} : 32'h0;
        end
        else if (paddr == cnrb_pkg::FILTER_EXT_OFS)
        begin
            rd = {16'h0, s_reg.filtExt};
        end
        else if (paddr == cnrb_pkg::BUF_CFG_OFS)
        begin
            rd = {10'h0, s_reg.progTx, s_reg.maskExt, s_reg.acceptAll};
        end
        else if (paddr == cnrb_pkg::STATUS_OFS)
        begin
            rd = {23'h0, s_reg.overflow, s_reg.full};
        end
        else if (paddr >= cnrb_pkg::FILTER_MAP_OFS &&
                 paddr <= cnrb_pkg::FILTER_MAP_END &&
                 paddr[1:0] == 2'h0)
        begin
            rd = enh ? {24'h0, s_reg.filtPtr[{paddr[4:2], 1'b1}],
                        s_reg.filtPtr[{paddr[4:2], 1'b0}]} : 32'h0;
        end
        else if (paddr >= cnrb_pkg::BUF_OFS &&
                 paddr <= cnrb_pkg::BUF_END && paddr[1:0] == 2'h0)
        begin
            if (paddr[3:2] == 2'h0)
            begin
                rd = {20'h0, s_reg.dlc[b], s_reg.full[b], s_reg.ext[b],
                      s_reg.rtr[b], s_reg.hit[b]};
            end
            else if (paddr[3:2] == 2'h1)
            begin
                rd = {3'h0, s_reg.ident[b]};
            end
            else if (paddr[3:2] == 2'h2)
            begin
                rd = s_reg.data[b][31:0];
            end
            else
            begin
                rd = s_reg.data[b][63:32];
            end
        end
        else
        begin
            err = 1'b1;
        end
        s_next.ready = acc;
        s_next.slverr = acc && err;
        if (acc)
        begin
            s_next.rdata = pwrite ? 32'h0 : rd;
        end

        // Register writes
        if (wr)
        begin
            if (paddr == cnrb_pkg::CTRL_OFS)
            begin
                s_next.opMode = pwdata[1:0];
                s_next.rxMode0 = pwdata[3:2];
                s_next.rxMode1 = pwdata[5:4];
                s_next.dblBuf = pwdata[6];
                s_next.rxIntEn = pwdata[7];
            end
            else if (paddr == cnrb_pkg::TX_IDENT_LOW_OFS && enh)
            begin
                s_next.txIdent = pwdata[7:0] &
                                 cnrb_pkg::TX_IDENT_LOW_WMASK;
            end
            else if (paddr == cnrb_pkg::FILTER_EXT_OFS)
            begin
                s_next.filtExt = pwdata[15:0];
            end
            else if (paddr == cnrb_pkg::BUF_CFG_OFS)
            begin
                s_next.acceptAll = pwdata[7:0];
                s_next.maskExt = pwdata[15:8];
                s_next.progTx = pwdata[21:16];
            end
            else if (paddr == cnrb_pkg::STATUS_OFS)
            begin
                s_next.full = s_reg.full & ~pwdata[7:0];
                s_next.overflow = s_reg.overflow && !pwdata[8];
            end
            else if (paddr >= cnrb_pkg::FILTER_MAP_OFS &&
                     paddr <= cnrb_pkg::FILTER_MAP_END && enh)
            begin
                s_next.filtPtr[{paddr[4:2], 1'b0}] = pwdata[3:0];
                s_next.filtPtr[{paddr[4:2], 1'b1}] = pwdata[7:4];
            end
        end

        // Candidate buffers for the assembled frame
        if (s_reg.state == cnrb_pkg::ST_ROUTE)
        begin
            if (!enh)
            begin
                for (int f = 5; f >= 0; f--)
                begin
                    if (s_reg.mabMatch[f] && !s_reg.mabPartial &&
                        typeOk((f < 2) ? s_reg.rxMode0 : s_reg.rxMode1,
                               s_reg.filtExt[f], s_reg.mabExt))
                    begin
                        cand[(f < 2) ? 0 : 1] = 1'b1;
                        hitIdx[(f < 2) ? 0 : 1] = 5'(f);
                    end
                end
                cand[0] = cand[0] || (s_reg.rxMode0 == cnrb_pkg::RXM_ANY);
                cand[1] = cand[1] || (s_reg.rxMode1 == cnrb_pkg::RXM_ANY);
                if (cand[0])
                begin
                    tgt = 3'h0;
                    load = !s_reg.full[0];
                    if (s_reg.full[0] && s_reg.dblBuf)
                    begin
                        tgt = 3'h1;
                        load = !s_reg.full[1];
                    end
                end
                else if (cand[1])
                begin
                    tgt = 3'h1;
                    load = !s_reg.full[1];
                end
                ovf = (cand[0] || cand[1]) && !load;
            end
            else
            begin
                for (int f = 15; f >= 0; f--)
                begin
                    p = s_reg.filtPtr[f];
                    pi = p[2:0] - 3'h2;
                    if (s_reg.mabMatch[f] && !s_reg.mabPartial &&
                        !p[3] && !(p[2:1] != 2'h0 && s_reg.progTx[pi]) &&
                        (!s_reg.maskExt[p[2:0]] ||
                         s_reg.filtExt[f] == s_reg.mabExt))
                    begin
                        cand[p[2:0]] = 1'b1;
                        hitIdx[p[2:0]] = 5'(f);
                    end
                end
                for (int k = 0; k < cnrb_pkg::NUM_BUF; k++)
                begin
                    if (s_reg.acceptAll[k] &&
                        !(k >= 2 && s_reg.progTx[(k >= 2) ? k - 2 : 0]))
                    begin
                        cand[k] = 1'b1;
                    end
                end
                tgt = lowest8(cand);
                load = (cand != 8'h00) && !s_reg.full[tgt];
                ovf = (cand != 8'h00) && s_reg.full[tgt];
            end
            if (load)
            begin
                s_next.ident[tgt] = s_reg.mabIdent;
                s_next.dlc[tgt] = s_reg.mabDlc;
                s_next.data[tgt] = s_reg.mabData;
                s_next.rtr[tgt] = s_reg.mabRtr;
                s_next.ext[tgt] = s_reg.mabExt;
                s_next.hit[tgt] = enh ? hitIdx[tgt] :
                                  {2'h0, hitIdx[tgt][2:0]};
                s_next.full[tgt] = 1'b1;
                s_next.irq = s_reg.rxIntEn;
            end
            s_next.overflow = s_next.overflow || ovf;
            s_next.state = cnrb_pkg::ST_IDLE;
        end

        if (frmDone || frmError)
        begin
            s_next.mabIdent = frmIdent;
            s_next.mabExt = frmExt;
            s_next.mabRtr = frmRtr;
            s_next.mabDlc = frmDlc;
            s_next.mabData = frmData;
            s_next.mabMatch = frmMatch;
            s_next.mabPartial = frmError;
            s_next.state = cnrb_pkg::ST_ROUTE;
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_reg <= '0;
            s_reg.state <= cnrb_pkg::ST_IDLE;
            s_reg.txIdent <= cnrb_pkg::TX_IDENT_LOW_RST;
            s_reg.filtPtr[7:0] <= {cnrb_pkg::MAP_RST_OTHER,
                                   cnrb_pkg::MAP_RST_2, cnrb_pkg::MAP_RST_1,
                                   cnrb_pkg::MAP_RST_0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = s_reg.rdata;
    assign pready = s_reg.ready;
    assign pslverr = s_reg.slverr;
    assign rxIrq = s_reg.irq;
    assign rxBufferFull = s_reg.full;
    assign rxOverflow = s_reg.overflow;
    assign txExtIdent = s_reg.txIdent[cnrb_pkg::TX_EXT_BIT];
    assign txIdentLow = s_reg.txIdent;
endmodule : cnrb_top
`default_nettype wire

// ### dv/cnrb_top_asserts.sv
// Checker for the receive routing block ports
`timescale 1ns/1ns
`default_nettype none
module cnrb_top_asserts (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frmDone,
    input wire logic frmError,
    input wire logic [28:0] frmIdent,
    input wire logic frmExt,
    input wire logic frmRtr,
    input wire logic [3:0] frmDlc,
    input wire logic [63:0] frmData,
    input wire logic [15:0] frmMatch,
    input wire logic rxIrq,
    input wire logic [7:0] rxBufferFull,
    input wire logic rxOverflow,
    input wire logic txExtIdent,
    input wire logic [7:0] txIdentLow
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Sequences and properties
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    a_apb_one_wait: assert property (s_setup ##1 s_wait |=> pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_tx_holes: assert property (
        txIdentLow[4] == 1'b0 && txIdentLow[2] == 1'b0)
        else $error("tx ident low hole bit set");
    a_tx_ext_bit: assert property (
        txExtIdent == txIdentLow[3])
        else $error("tx ext enable differs from bit 3");
    a_full_cause: assert property (
        (rxBufferFull & ~$past(rxBufferFull)) != 8'h00
        |-> $past(frmDone || frmError, 2))
        else $error("full flag set without frame");
    a_full_clear: assert property (
        (~rxBufferFull & $past(rxBufferFull)) != 8'h00
        |-> $past(pready && pwrite))
        else $error("full flag cleared without write");
    a_irq_load: assert property (
        rxIrq |-> (rxBufferFull & ~$past(rxBufferFull)) != 8'h00)
        else $error("irq without buffer load");
    a_ovf_cause: assert property (
        $rose(rxOverflow) |-> $past(frmDone || frmError, 2))
        else $error("overflow without frame");
    a_ovf_sticky: assert property (
        $fell(rxOverflow) |-> $past(pready && pwrite))
        else $error("overflow cleared without write");
endmodule : cnrb_top_asserts
bind cnrb_top cnrb_top_asserts cnrb_top_asserts_i (.ref_clk, .arst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .frmDone, .frmError, .frmIdent, .frmExt, .frmRtr, .frmDlc, .frmData,
    .frmMatch, .rxIrq, .rxBufferFull, .rxOverflow, .txExtIdent,
    .txIdentLow);
`default_nettype wire

// ### dv/cnrb_can_model.sv
// Frame source standing in for the bus side
`timescale 1ns/1ns
`default_nettype none
module cnrb_can_model (
    input wire logic ref_clk,
    output var logic frmDone,
    output var logic frmError,
    output var logic [28:0] frmIdent,
    output var logic frmExt,
    output var logic frmRtr,
    output var logic [3:0] frmDlc,
    output var logic [63:0] frmData,
    output var logic [15:0] frmMatch
);
    // ==========================================================
    // Frame delivery
    initial
    begin
        {frmDone, frmError, frmIdent, frmExt, frmRtr} = '0;
        {frmDlc, frmData, frmMatch} = '0;
    end
    task automatic send(input logic [28:0] id, input logic ext,
        input logic rtr, input logic [15:0] m, input logic err);
        frmDone <= !err;
        frmError <= err;
        frmIdent <= id;
        frmExt <= ext;
        frmRtr <= rtr;
        frmDlc <= id[3:0];
        frmData <= {2{3'h0, id}};
        frmMatch <= m;
        @(posedge ref_clk);
        frmDone <= 1'b0;
        frmError <= 1'b0;
        {frmIdent, frmExt, frmRtr} <= ~{id, ext, rtr};
        {frmDlc, frmData, frmMatch} <= ~{id[3:0], {2{3'h0, id}}, m};
    endtask : send
endmodule : cnrb_can_model
`default_nettype wire

// ### dv/cnrb_top_tb.sv
// Self-checking bench for the receive routing block
`timescale 1ns/1ns
`default_nettype none
module cnrb_top_tb;
    logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, lastErr;
    logic frmDone, frmError, frmExt, frmRtr, rxIrq, rxOverflow, txExtIdent;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [28:0] frmIdent;
    logic [3:0] frmDlc;
    logic [63:0] frmData;
    logic [15:0] frmMatch;
    logic [7:0] rxBufferFull, txIdentLow;
    int errors, n_tests, irqCnt;
    cnrb_top cnrb_top_i (.ref_clk, .arst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .frmDone, .frmError,
        .frmIdent, .frmExt, .frmRtr, .frmDlc, .frmData, .frmMatch, .rxIrq,
        .rxBufferFull, .rxOverflow, .txExtIdent, .txIdentLow);
    cnrb_can_model cnrb_can_model_i (.ref_clk, .frmDone, .frmError,
        .frmIdent, .frmExt, .frmRtr, .frmDlc, .frmData, .frmMatch);
    // ==========================================================
    // Clock, monitors and helpers
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (rxIrq === 1'b1)
            irqCnt++;
    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (k >= 20)
        begin
            errors++;
            test_done();
        end
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic stat(input logic [31:0] exp);
        rdchk(cnrb_pkg::STATUS_OFS, exp);
        chk({23'h0, rxOverflow, rxBufferFull}, exp);
        apb(1'b1, cnrb_pkg::STATUS_OFS, 32'h1FF);
    endtask : stat
    task automatic frm(input logic [28:0] id, input logic ext,
        input logic rtr, input logic [15:0] m, input logic err);
        cnrb_can_model_i.send(id, ext, rtr, m, err);
        repeat (2) @(posedge ref_clk);
    endtask : frm
    function automatic logic [31:0] w0(input logic [28:0] id,
        input logic ext, input logic rtr, input logic [4:0] hit);
        return {20'h0, id[3:0], 1'b1, ext, rtr, hit};
    endfunction : w0
    // ==========================================================
    // Scenarios
    task automatic scen_regs();
        logic [7:0] rst [4] = '{8'h00, 8'h11, 8'h11, 8'h00};
        rdchk(cnrb_pkg::FILTER_MAP_OFS + 12'h4, 32'h0);
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'h1);
        for (int n = 0; n < 4; n++)
            rdchk(cnrb_pkg::FILTER_MAP_OFS + 12'(4 * n), {24'h0, rst[n]});
        apb(1'b1, cnrb_pkg::FILTER_MAP_END, 32'hA5);
        rdchk(cnrb_pkg::FILTER_MAP_END, 32'hA5);
        apb(1'b1, cnrb_pkg::TX_IDENT_LOW_OFS, 32'hFF);
        rdchk(cnrb_pkg::TX_IDENT_LOW_OFS, 32'hEB);
        chk({31'h0, txExtIdent}, 32'h1);
        chk({24'h0, txIdentLow}, 32'hEB);
        apb(1'b1, cnrb_pkg::TX_IDENT_LOW_OFS, 32'h13);
        rdchk(cnrb_pkg::TX_IDENT_LOW_OFS, 32'h03);
        chk({31'h0, txExtIdent}, 32'h0);
        rdchk(12'hFFC, 32'h0);
        chk({31'h0, lastErr}, 32'h1);
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'h0);
        rdchk(cnrb_pkg::TX_IDENT_LOW_OFS, 32'h0);
    endtask : scen_regs
    task automatic scen_mode0();
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'h80);
        apb(1'b1, cnrb_pkg::FILTER_EXT_OFS, 32'h0);
        frm(29'h123, 1'b0, 1'b1, 16'h0002, 1'b0);
        frm(29'h456, 1'b0, 1'b0, 16'h0001, 1'b0);
        rdchk(cnrb_pkg::BUF_OFS, w0(29'h123, 1'b0, 1'b1, 5'h1));
        chk({31'h0, rd[5]}, 32'h1);
        rdchk(cnrb_pkg::BUF_OFS + 12'h4, 32'h123);
        rdchk(cnrb_pkg::BUF_OFS + 12'h8, 32'h123);
        stat(32'h101);
        frm(29'h7A5, 1'b0, 1'b0, 16'h0008, 1'b0);
        rdchk(cnrb_pkg::BUF_OFS + 12'h10, w0(29'h7A5, 1'b0, 1'b0, 5'h3));
        stat(32'h2);
    endtask : scen_mode0
    task automatic scen_dbl();
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'hC0);
        frm(29'h0AA, 1'b0, 1'b0, 16'h0001, 1'b0);
        frm(29'h0BB, 1'b0, 1'b0, 16'h0001, 1'b0);
        rdchk(cnrb_pkg::BUF_OFS + 12'h14, 32'hBB);
        stat(32'h3);
    endtask : scen_dbl
    task automatic scen_rxmode();
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'h84);
        apb(1'b1, cnrb_pkg::FILTER_EXT_OFS, 32'h1);
        frm(29'h1ABCDEF, 1'b1, 1'b0, 16'h0001, 1'b0);
        frm(29'h012, 1'b0, 1'b0, 16'h0001, 1'b0);
        stat(32'h0);
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'h88);
        frm(29'h1ABCDEF, 1'b1, 1'b0, 16'h0001, 1'b0);
        rdchk(cnrb_pkg::BUF_OFS, w0(29'h1ABCDEF, 1'b1, 1'b0, 5'h0));
        stat(32'h1);
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'h8C);
        frm(29'h321, 1'b0, 1'b0, 16'h0000, 1'b1);
        rdchk(cnrb_pkg::BUF_OFS + 12'h4, 32'h321);
        stat(32'h1);
    endtask : scen_rxmode
    task automatic scen_mode1();
        apb(1'b1, cnrb_pkg::CTRL_OFS, 32'h81);
        apb(1'b1, cnrb_pkg::FILTER_EXT_OFS, 32'h0);
        apb(1'b1, cnrb_pkg::FILTER_MAP_OFS + 12'h8, 32'h32);
        apb(1'b1, cnrb_pkg::BUF_CFG_OFS, 32'h0);
        frm(29'h044, 1'b0, 1'b0, 16'h0030, 1'b0);
        rdchk(cnrb_pkg::BUF_OFS + 12'h20, w0(29'h044, 1'b0, 1'b0, 5'h4));
        stat(32'h4);
        apb(1'b1, cnrb_pkg::BUF_CFG_OFS, 32'h10000);
        frm(29'h045, 1'b0, 1'b0, 16'h0010, 1'b0);
        stat(32'h0);
        apb(1'b1, cnrb_pkg::BUF_CFG_OFS, 32'h0800);
        frm(29'h1234567, 1'b1, 1'b0, 16'h0020, 1'b0);
        stat(32'h0);
        apb(1'b1, cnrb_pkg::BUF_CFG_OFS, 32'h0);
        frm(29'h1234567, 1'b1, 1'b0, 16'h0020, 1'b0);
        stat(32'h8);
    endtask : scen_mode1
    // ==========================================================
    // Main sequence
    initial
    begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        scen_regs();
        scen_mode0();
        scen_dbl();
        scen_rxmode();
        scen_mode1();
        chk(32'(irqCnt), 32'h8);
        test_done();
    end
endmodule : cnrb_top_tb
`default_nettype wire
